// File: hw/islc_pkg.sv
// Purpose: shared constants and types for the i2c sequence loop controller
// Assumes: 50 MHz mclk, classic wishbone register port, 32-bit data
// Notes: one byte per transaction record, fixed small sequence memory
package islc_pkg;
   // register byte offsets
   localparam logic [7:0] ISLC_CTRL_OFS = 8'h00;
   localparam logic [7:0] ISLC_STAT_OFS = 8'h04;
   localparam logic [7:0] ISLC_MASK_OFS = 8'h08;
   localparam logic [7:0] ISLC_RATE_OFS = 8'h0C;
   localparam logic [7:0] ISLC_CNT_OFS = 8'h10;
   localparam logic [7:0] ISLC_SEQ_OFS = 8'h14;
   localparam logic [7:0] ISLC_RES_OFS = 8'h18;
   localparam logic [7:0] ISLC_JOB_OFS = 8'h1C;
   localparam logic [7:0] ISLC_ID_OFS = 8'h20;
   // identity value, arbitrary
   localparam logic [7:0] ISLC_ID_VALUE = 8'h3C;
   // control bit positions
   localparam int ISLC_C_BEGIN = 0;
   localparam int ISLC_C_HALT = 1;
   localparam int ISLC_C_HALTSEQ = 2;
   localparam int ISLC_C_PIN = 3;
   localparam int ISLC_C_POL = 4;
   localparam int ISLC_C_AHEAL = 5;
   localparam int ISLC_C_MHEAL = 6;
   // status bit positions
   localparam int ISLC_S_DONE = 0;
   localparam int ISLC_S_LOOP = 1;
   localparam int ISLC_S_OVR = 2;
   localparam int ISLC_S_STUCK = 3;
   localparam int ISLC_S_NACK = 4;
   localparam int ISLC_S_BUSY = 7;
   // sequence memory
   localparam int ISLC_SEQ_DEPTH = 8;
   localparam int ISLC_SEQ_AW = 3;
   // i2c timing: quarter bit of 1 MHz scl
   localparam int ISLC_CLK_MHZ = 50;
   localparam int ISLC_QTR_NS = 250;
   localparam int ISLC_QTR_CYC = (ISLC_QTR_NS * ISLC_CLK_MHZ) / 1000;
   // frame_interval unit in microseconds
   localparam int ISLC_TICK_US = 1;
   localparam int ISLC_TICK_CYC = ISLC_TICK_US * ISLC_CLK_MHZ;
   localparam logic [3:0] ISLC_HEAL_PULSES = 4'h9;
   localparam logic [3:0] ISLC_BITS = 4'h8;

   // one sequence entry: address with direction, one data byte
   typedef struct packed {
      logic [6:0] addr;
      logic rd;
      logic [7:0] data;
   } islc_entry_t;

   // bus line controls: 1 drives low
   typedef struct packed {
      logic scl_low;
      logic sda_low;
   } islc_lines_t;

   typedef enum logic [10:0] {
      ISLC_IDLE = 11'b000_0000_0001,
      ISLC_ARM = 11'b000_0000_0010,
      ISLC_START = 11'b000_0000_0100,
      ISLC_BIT = 11'b000_0000_1000,
      ISLC_ACK = 11'b000_0001_0000,
      ISLC_STOP = 11'b000_0010_0000,
      ISLC_WAIT = 11'b000_0100_0000,
      ISLC_HEAL = 11'b000_1000_0000,
      ISLC_HSTOP = 11'b001_0000_0000,
      ISLC_MHEAL = 11'b010_0000_0000,
      ISLC_RSTRT = 11'b100_0000_0000
   } islc_state_t;
endpackage

// File: hw/islc_core.sv
// Purpose: i2c sequence engine with halt, looping, pacing and sda heal
// Assumes: wishbone classic slave, ack one cycle after stb, pins sampled
// Notes: each sequence entry is one slave address plus one data byte
// Function
// - clear job pending after read completes
// - halt in write stops after ack
// - halt on address read: nine clocks, nack
// - halt in read data nacks, stops
// - halt sets sequence complete, interrupt unless masked
// - halt in loop sets both flags
// - restart after halt begins at first entry
// - frame interval paces starts, zero back-to-back
// - pin pacing ignores frame interval
// - repeat count reached sets loop flag, idle
// - repeat count zero loops forever
// - loop mask gates loop interrupt only
// - timer mode starts immediately then periodically
// - interval expiring early sets overrun
// - pin mode begin only arms trigger
// - trigger during sequence sets overrun
// - trigger edge polarity selectable
// - stuck sda checked only at start and at the end of the heal stop
// - auto heal: nine pulses, stop, retry
// - heal fails: stuck flag, release lines
// - manual heal pulses; begin restarts sequence
// - success: stop, complete flag, interrupt
`timescale 1ns/1ps
module islc_core
   import islc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   input wire logic trig_i,
   output logic irq
);
   // sequence memory, written by host only
   islc_entry_t seq_mem [ISLC_SEQ_DEPTH];

   // all module state but seq_mem in one record
   typedef struct packed {
      islc_state_t st;
      logic [7:0] ctrl;       // persistent control bits
      logic [7:0] stat;       // sticky flags
      logic [7:0] mask;       // interrupt masks
      logic [7:0] rate;       // frame_interval
      logic [7:0] cnt;        // repeat_count
      logic [ISLC_SEQ_AW:0] len; // entries in sequence
      logic [7:0] jobs;       // job_pending per entry
      logic [7:0] accepted;   // job_accepted per entry
      logic [7:0] rxd;        // last received byte
      logic [ISLC_SEQ_AW-1:0] idx;
      logic [ISLC_SEQ_AW-1:0] ridx;
      logic [7:0] frames;     // frames done
      logic [7:0] sh;         // shift register
      logic [3:0] nbit;
      logic [1:0] ph;         // quarter phase
      logic [5:0] qcnt;
      logic [5:0] tcnt;       // microsecond prescaler
      logic [7:0] tick;       // interval count
      logic in_data;          // in the data byte, sent or received
      logic halt;             // halt pending
      logic halt_seq;         // halt after sequence
      logic retry;            // cleared at each start, never set
      logic [1:0] trig_s;     // trigger synchroniser
      logic trig_d;
      logic [1:0] sda_s;
      logic [1:0] scl_s;
      islc_lines_t ln;
      logic ack;
      logic [31:0] rdat;
   } islc_reg_t;

   islc_reg_t r, next_r;

   // any repeat_count other than one, zero included, means loop mode
   function automatic logic loop_mode(input logic [7:0] c);
      return c != 8'h01;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      return a == o;
   endfunction

   // sequence memory writes, no reset needed for contents
   always_ff @(posedge mclk) begin
      if (wb_cyc_i && wb_stb_i && wb_we_i && !r.ack
          && hit(wb_adr_i, ISLC_SEQ_OFS) && wb_sel_i[0]) begin
         seq_mem[wb_dat_i[18:16]] <= wb_dat_i[15:0];
      end
   end

   // one combinational next-state process
   always_comb begin
      islc_entry_t e;
      logic qtick, sda_in, trig_edge, trig_raw, wr, rd_acc;
      logic frame_start;
      e = seq_mem[r.idx];
      next_r = r;
      frame_start = 1'b0;
      // pin synchronisers
      next_r.trig_s = {r.trig_s[0], trig_i};
      next_r.sda_s = {r.sda_s[0], sda_i};
      next_r.scl_s = {r.scl_s[0], scl_i};
      sda_in = r.sda_s[1];
      next_r.trig_d = r.trig_s[1];
      trig_raw = r.ctrl[ISLC_C_POL] ? (!r.trig_s[1] && r.trig_d)
                                    : (r.trig_s[1] && !r.trig_d);
      trig_edge = trig_raw && r.ctrl[ISLC_C_PIN];
      // quarter-bit timer runs free in every state
      qtick = (r.qcnt == 6'(ISLC_QTR_CYC - 1));
      next_r.qcnt = qtick ? 6'h00 : r.qcnt + 6'h01;
      // frame interval timer counts microseconds
      if (r.tcnt == 6'(ISLC_TICK_CYC - 1)) begin
         next_r.tcnt = 6'h00;
         if (r.st != ISLC_IDLE && !r.ctrl[ISLC_C_PIN]) begin
            next_r.tick = r.tick + 8'h01;
         end
      end else begin
         next_r.tcnt = r.tcnt + 6'h01;
      end
      // bus slave: ack one cycle after strobe, drop next cycle
      wr = wb_cyc_i && wb_stb_i && wb_we_i && !r.ack && wb_sel_i[0];
      rd_acc = wb_cyc_i && wb_stb_i && !wb_we_i && !r.ack;
      next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
      next_r.rdat = 32'h0000_0000;
      if (rd_acc) begin
         unique case (wb_adr_i)
            ISLC_CTRL_OFS: next_r.rdat[7:0] = r.ctrl;
            ISLC_STAT_OFS: next_r.rdat[7:0] = r.stat |
               {(r.st != ISLC_IDLE), 7'h00};
            ISLC_MASK_OFS: next_r.rdat[7:0] = r.mask;
            ISLC_RATE_OFS: next_r.rdat[7:0] = r.rate;
            ISLC_CNT_OFS: next_r.rdat[7:0] = r.cnt;
            ISLC_SEQ_OFS: next_r.rdat[3:0] = 4'(r.len);
            ISLC_RES_OFS: next_r.rdat[7:0] = r.rxd;
            ISLC_JOB_OFS: next_r.rdat[15:0] = {r.accepted, r.jobs};
            ISLC_ID_OFS: next_r.rdat[7:0] = ISLC_ID_VALUE;
            default: next_r.rdat = 32'h0000_0000; // unmapped reads zero
         endcase
      end
      // status write-one-to-clear; hardware sets below win
      if (wr && hit(wb_adr_i, ISLC_STAT_OFS)) begin
         next_r.stat = r.stat & ~wb_dat_i[7:0];
      end
      if (wr && hit(wb_adr_i, ISLC_MASK_OFS)) next_r.mask = wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, ISLC_RATE_OFS)) next_r.rate = wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, ISLC_CNT_OFS)) next_r.cnt = wb_dat_i[7:0];
      if (wr && hit(wb_adr_i, ISLC_SEQ_OFS)) begin
         if (wb_dat_i[19]) next_r.len = wb_dat_i[23:20];
      end
      if (wr && hit(wb_adr_i, ISLC_CTRL_OFS)) begin
         next_r.ctrl = wb_dat_i[7:0];
         if (wb_dat_i[ISLC_C_HALT] && r.st != ISLC_IDLE) next_r.halt = 1'b1;
         if (wb_dat_i[ISLC_C_HALTSEQ] && r.st != ISLC_IDLE) begin
            next_r.halt_seq = 1'b1;
         end
      end
      // halt commands are never held in ctrl; begin and heal clear once taken
      next_r.ctrl[ISLC_C_HALT] = 1'b0;
      next_r.ctrl[ISLC_C_HALTSEQ] = 1'b0;
      unique case (r.st)
         ISLC_IDLE: begin
            next_r.ln = '0;
            if (r.ctrl[ISLC_C_MHEAL]) begin
               next_r.st = ISLC_MHEAL;
               next_r.nbit = 4'h0;
               next_r.ctrl[ISLC_C_MHEAL] = 1'b0;
            end else if (r.ctrl[ISLC_C_BEGIN] && r.len != '0) begin
               next_r.ctrl[ISLC_C_BEGIN] = 1'b0;
               next_r.frames = 8'h00;
               next_r.halt = 1'b0;
               next_r.halt_seq = 1'b0;
               next_r.idx = '0;
               next_r.jobs = 8'hFF >> (4'h8 - 4'(r.len));
               next_r.accepted = 8'h00;
               // pin mode waits for an edge
               next_r.st = r.ctrl[ISLC_C_PIN] ? ISLC_ARM : ISLC_START;
               frame_start = !r.ctrl[ISLC_C_PIN];
            end
         end
         ISLC_ARM, ISLC_WAIT: begin
            // pin pacing ignores frame_interval
            if (r.halt || r.halt_seq) begin
               next_r.stat[ISLC_S_DONE] = 1'b1;
               next_r.stat[ISLC_S_LOOP] = loop_mode(r.cnt);
               next_r.st = ISLC_IDLE;
            end else if (r.ctrl[ISLC_C_PIN] ? trig_edge
                         : (r.tick >= r.rate)) begin
               next_r.st = ISLC_START;
               next_r.idx = '0;
               next_r.jobs = 8'hFF >> (4'h8 - 4'(r.len));
               frame_start = 1'b1;
            end
         end
         ISLC_START, ISLC_RSTRT: if (qtick) begin
            next_r.ph = r.ph + 2'h1;
            if (r.ph == 2'h0) next_r.ln = '{scl_low: 1'b0, sda_low: 1'b0};
            if (r.ph == 2'h1) begin
               // stuck sda seen here and at the end of the heal stop
               if (!sda_in) begin
                  next_r.st = ISLC_HEAL;
                  next_r.nbit = 4'h0;
                  next_r.ph = 2'h0;
               end else next_r.ln.sda_low = 1'b1;
            end
            if (r.ph == 2'h3) begin
               next_r.ln.scl_low = 1'b1;
               next_r.accepted[r.idx] = 1'b1;
               next_r.retry = 1'b0;
               next_r.sh = {e.addr, e.rd};
               next_r.nbit = 4'h0;
               next_r.in_data = 1'b0;
               // the address byte goes out first
               next_r.st = ISLC_BIT;
            end
         end
         ISLC_BIT: if (qtick) begin
            // one bit per four quarters: set, rise, sample, fall
            next_r.ph = r.ph + 2'h1;
            unique case (r.ph)
               2'h0: next_r.ln.sda_low = (r.in_data && e.rd) ? 1'b0
                                         : !r.sh[7];
               2'h1: next_r.ln.scl_low = 1'b0;
               2'h2: next_r.sh = {r.sh[6:0], sda_in};
               default: begin
                  next_r.ln.scl_low = 1'b1;
                  next_r.nbit = r.nbit + 4'h1;
                  if (r.nbit == ISLC_BITS - 4'h1) begin
                     next_r.nbit = 4'h0;
                     next_r.st = ISLC_ACK;
                  end
               end
            endcase
         end
         ISLC_ACK: if (qtick) begin
            next_r.ph = r.ph + 2'h1;
            unique case (r.ph)
               // one byte per read, always the last: the master
               // nacks it; a halt on the address read costs one
               // such byte before the stop
               2'h0: next_r.ln.sda_low = 1'b0;
               2'h1: next_r.ln.scl_low = 1'b0;
               2'h2: if (!(r.in_data && e.rd) && sda_in) begin
                  next_r.stat[ISLC_S_NACK] = 1'b1;
                  next_r.halt = 1'b1;
               end
               default: begin
                  next_r.ln.scl_low = 1'b1;
                  if (r.in_data && e.rd) begin
                     next_r.rxd = r.sh;
                     next_r.jobs[r.idx] = 1'b0;
                  end else if (r.in_data) begin
                     next_r.jobs[r.idx] = 1'b0;
                  end
                  if (!r.in_data && e.rd && r.halt) begin
                     // halted read: one byte more, nacked, then stop
                     next_r.in_data = 1'b1;
                     next_r.st = ISLC_BIT;
                  end else if (r.halt) begin
                     next_r.st = ISLC_STOP;
                  end else if (!r.in_data) begin
                     next_r.in_data = 1'b1;
                     next_r.sh = e.data;
                     next_r.st = ISLC_BIT;
                  end else if (4'(r.idx) + 4'h1 < 4'(r.len)) begin
                     next_r.idx = r.idx + 1'b1;
                     next_r.st = ISLC_RSTRT;
                  end else begin
                     next_r.st = ISLC_STOP;
                  end
               end
            endcase
         end
         ISLC_STOP, ISLC_HSTOP: if (qtick) begin
            next_r.ph = r.ph + 2'h1;
            if (r.ph == 2'h0) next_r.ln.sda_low = 1'b1;
            if (r.ph == 2'h1) next_r.ln.scl_low = 1'b0;
            if (r.ph == 2'h2) next_r.ln.sda_low = 1'b0;
            if (r.ph == 2'h3 && r.st == ISLC_HSTOP) begin
               // retry start once after heal
               if (sda_in) next_r.st = ISLC_RSTRT;
               else begin
                  next_r.stat[ISLC_S_STUCK] = 1'b1;
                  next_r.ln = '0;
                  next_r.st = ISLC_IDLE;
               end
            end else if (r.ph == 2'h3) begin
               next_r.stat[ISLC_S_DONE] = 1'b1;
               next_r.frames = r.frames + 8'h01;
               if (r.halt || r.halt_seq) begin
                  next_r.stat[ISLC_S_LOOP] = loop_mode(r.cnt);
                  next_r.st = ISLC_IDLE;
               end else if (r.cnt != 8'h00
                            && r.frames + 8'h01 >= r.cnt) begin
                  next_r.stat[ISLC_S_LOOP] = 1'b1;
                  next_r.st = ISLC_IDLE;
               end else begin
                  next_r.st = ISLC_WAIT;
               end
            end
         end
         ISLC_HEAL, ISLC_MHEAL: begin
            if (r.st == ISLC_HEAL && !r.ctrl[ISLC_C_AHEAL]) begin
               next_r.stat[ISLC_S_STUCK] = 1'b1;
               next_r.ln = '0;
               next_r.st = ISLC_IDLE;
            end else if (qtick) begin
               next_r.ph = r.ph + 2'h1;
               next_r.ln.sda_low = 1'b0;
               if (r.ph == 2'h1) next_r.ln.scl_low = 1'b0;
               if (r.ph == 2'h3) begin
                  next_r.ln.scl_low = 1'b1;
                  next_r.nbit = r.nbit + 4'h1;
                  if (r.nbit == ISLC_HEAL_PULSES - 4'h1) begin
                     next_r.st = (r.st == ISLC_HEAL) ? ISLC_HSTOP
                                                     : ISLC_IDLE;
                     if (r.st == ISLC_MHEAL) next_r.ln = '0;
                  end
               end
            end
         end
         default: next_r.st = ISLC_IDLE;
      endcase
      // overrun: frame due while sequence still on the bus
      if (r.st != ISLC_IDLE && r.st != ISLC_ARM && r.st != ISLC_WAIT) begin
         if (trig_edge) next_r.stat[ISLC_S_OVR] = 1'b1;
         if (!r.ctrl[ISLC_C_PIN] && r.rate != 8'h00 && r.tick >= r.rate) begin
            next_r.stat[ISLC_S_OVR] = 1'b1;
            next_r.tick = 8'h00;
         end
      end
      if (frame_start) next_r.tick = 8'h00;
   end

   // state register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r <= '{st: ISLC_IDLE, cnt: 8'h01, sda_s: 2'b11, scl_s: 2'b11,
                default: '0};
      end else begin
         r <= next_r;
      end
   end

   // outputs: open drain, enable high while pulling low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = r.ln.scl_low;
   assign sda_oe = r.ln.sda_low;
   assign wb_ack_o = r.ack;
   assign wb_dat_o = r.rdat;
   // halt completion sets done but masked bits keep irq low
   assign irq = |(r.stat[4:0] & ~r.mask[4:0]);
endmodule

// File: verification/islc_chk.sv
// Purpose: port-level checks for the i2c sequence loop controller
// Assumes: one mclk domain, rst asynchronous and active high
// Notes: attached by bind, watches only the ports of islc_core
`timescale 1ns/1ps
module islc_chk
   import islc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   input wire logic trig_i,
   input wire logic irq
);
   logic [5:0] idle_cnt; // cycles with both lines let go
   // saturating, so a long idle never wraps back to a false busy
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         idle_cnt <= 6'h00;
      end else if (scl_oe || sda_oe) begin
         idle_cnt <= 6'h00;
      end else if (idle_cnt != 6'h3f) begin
         idle_cnt <= idle_cnt + 6'h01;
      end
   end
   logic [10:0] halt_age; // halt wait
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         halt_age <= 11'h000;
      end else if (wb_ack_o && wb_we_i && wb_dat_i[ISLC_C_HALT] &&
                   wb_adr_i == ISLC_CTRL_OFS) begin
         halt_age <= 11'h001;
      end else if (halt_age != 11'h000) begin
         halt_age <= (idle_cnt > 6'd39) ? 11'h000 : halt_age + 11'h001;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_ack_answer: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("request not answered by a one-cycle ack");
   a_ack_cause: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   a_reset_quiet: assert property (
      $past(rst) |-> !scl_oe && !sda_oe && !irq)
      else $error("lines or irq active right after reset");
   a_pins_low: assert property (
      !scl_o && !sda_o) else $error("open-drain data not low");
   a_halt_stop: assert property (
      halt_age <= 11'd1500)
      else $error("halt did not leave the bus idle");
   a_irq_masked: assert property (
      wb_ack_o && $past(wb_we_i && wb_sel_i[0] &&
      wb_adr_i == ISLC_MASK_OFS && wb_dat_i[4:0] == 5'h1f) |-> ##2 !irq)
      else $error("irq raised with every source masked");
   a_scl_low: assert property (
      $rose(scl_oe) |=> scl_oe [*6])
      else $error("scl low phase too short");
   a_start_shape: assert property (
      $rose(sda_oe) && !scl_oe && $past(sda_i) |-> ##[1:30] scl_oe)
      else $error("start not followed by scl low");
endmodule

// File: verification/islc_slave.sv
// Purpose: behavioural i2c slave facing the loop controller
// Assumes: lines resolved by the bench, no clock stretching
// Notes: stuck holds sda low like a slave that lost bit sync
`timescale 1ns/1ps
module islc_slave #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic stuck,
   input wire logic [7:0] rd_byte,
   output logic sda_low,
   output logic [7:0] last_wr,
   output int starts
);
   int bitn = 0; // bit slot of the byte, 8 is the ack slot
   logic ph = 1'b0; // 0 address byte, 1 data byte
   logic sel = 1'b0; // addressed
   logic rd = 1'b0; // master reads
   logic drv = 1'b0; // pulling sda low
   logic [7:0] sh = 8'h00; // shift register
   initial starts = 0;
   assign sda_low = drv || stuck;
   // start or repeated start: new framing, counted per start
   always @(negedge sda) begin
      if (scl && !stuck) begin
         bitn = 0;
         ph = 1'b0;
         sel = 1'b0;
         starts++;
      end
   end
   // sample on rising scl; a nack from the master ends our reply
   always @(posedge scl) begin
      if (bitn < 8) begin
         sh = {sh[6:0], sda};
      end else if (ph && rd && sda) begin
         sel = 1'b0;
      end
      bitn++;
   end
   // drive on falling scl only, so sda never moves while scl is high
   always @(negedge scl) begin
      if (bitn == 8) begin
         if (!ph) begin
            sel = (sh[7:1] == ADDR);
            rd = sh[0];
         end else if (sel && !rd) begin
            last_wr = sh;
         end
         drv = sel && !(ph && rd);
      end else if (bitn == 9) begin
         bitn = 0;
         ph = 1'b1;
         drv = sel && rd && !rd_byte[7];
      end else begin
         drv = sel && rd && ph && !rd_byte[7 - bitn];
      end
   end
endmodule

// File: verification/islc_core_test.sv
// Purpose: self-checking bench for the i2c sequence loop controller
// Assumes: one slave model at address 2a, lines pulled up here
// Notes: expected bytes and start counts are worked out in the bench
`timescale 1ns/1ps
module islc_core_test;
   import islc_pkg::*;
   localparam logic [6:0] SLV = 7'h2a; // slave address
   logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic trig = 1'b0, stuck = 1'b0; // trigger pin, slave jams sda
   logic [7:0] adr = 8'h00, rbyte = 8'h00, wbyte, last_wr;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0000_0000, dout, rdat;
   logic ack, scl_o, scl_oe, sda_o, sda_oe, irq, s_low, scl, sda;
   int starts, s0, rnd, bad_count = 0, compares = 0;
   logic [7:0] ofs [6] = '{ISLC_STAT_OFS, ISLC_MASK_OFS, ISLC_RATE_OFS,
      ISLC_CNT_OFS, ISLC_ID_OFS, 8'h30};
   logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h1,
      {24'h0, ISLC_ID_VALUE}, 32'h0};
   // pull-ups: a line is low while anyone pulls it
   assign scl = !scl_oe;
   assign sda = !(sda_oe || s_low);
   always #10 mclk = ~mclk;
   islc_core i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dout), .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .trig_i(trig), .irq(irq));
   islc_slave #(.ADDR(SLV)) i_slave (.scl(scl), .sda(sda), .stuck(stuck),
      .rd_byte(rbyte), .sda_low(s_low), .last_wr(last_wr), .starts(starts));
   // one counted compare, reported at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // classic wishbone cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      @(posedge mclk);
      while (ack !== 1'b1) @(posedge mclk);
      rdat = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // poll status until a flag shows, bounded
   task automatic wait_bit(input int b);
      int n;
      n = 0;
      rdat = 32'h0;
      while (rdat[b] !== 1'b1 && n < 3000) begin
         bus(1'b0, ISLC_STAT_OFS, 32'h0);
         n++;
      end
      chk({31'h0, rdat[b]}, 32'h1);
   endtask
   // clear flags, set count and interval, then write control
   task automatic go(input logic [7:0] c, input logic [7:0] cnt,
      input logic [7:0] rt);
      bus(1'b1, ISLC_STAT_OFS, 32'h0000_001f);
      bus(1'b1, ISLC_CNT_OFS, {24'h0, cnt});
      bus(1'b1, ISLC_RATE_OFS, {24'h0, rt});
      s0 = starts;
      bus(1'b1, ISLC_CTRL_OFS, {24'h0, c});
   endtask
   // one trigger period of 160 ns: active edge, then the idle edge
   task automatic pulse(input logic p);
      @(posedge mclk);
      trig <= !p;
      repeat (4) @(posedge mclk);
      trig <= p;
      repeat (4) @(posedge mclk);
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      rnd = $urandom(32'h73ef);
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      bus(1'b1, 8'h30, 32'hffff_ffff);
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, ofs[i], 32'h0);
         chk(rdat, rv[i]);
      end
      wbyte = 8'($urandom());
      rbyte = 8'($urandom());
      bus(1'b1, ISLC_SEQ_OFS, {8'h0, 4'h2, 1'b1, 3'h0, SLV, 1'b0, wbyte});
      bus(1'b1, ISLC_SEQ_OFS, {12'h0, 1'b0, 3'h1, SLV, 1'b1, 8'h00});
      go(8'h01, 8'h01, 8'h00);
      wait_bit(ISLC_S_DONE);
      chk({31'h0, irq}, 32'h1);
      chk(32'(starts - s0), 32'd2);
      chk({24'h0, last_wr}, {24'h0, wbyte});
      bus(1'b0, ISLC_RES_OFS, 32'h0);
      chk(rdat, {24'h0, rbyte});
      bus(1'b0, ISLC_JOB_OFS, 32'h0);
      chk({24'h0, rdat[7:0]}, 32'h0);
      bus(1'b1, ISLC_MASK_OFS, 32'h0000_001f);
      repeat (3) @(posedge mclk);
      chk({31'h0, irq}, 32'h0);
      go(8'h01, 8'h03, 8'h00);
      wait_bit(ISLC_S_LOOP);
      repeat (2000) @(posedge mclk);
      chk(32'(starts - s0), 32'd6);
      go(8'h01, 8'h02, 8'd100);
      repeat (2500) @(posedge mclk);
      chk(32'(starts - s0), 32'd2);
      wait_bit(ISLC_S_LOOP);
      chk(32'(starts - s0), 32'd4);
      go(8'h01, 8'h02, 8'h01);
      wait_bit(ISLC_S_LOOP);
      chk({31'h0, rdat[ISLC_S_OVR]}, 32'h1);
      // endless loop ended by halt at a random point, or after a frame
      for (int i = 0; i < 4; i++) begin
         go(8'h01, 8'h00, 8'h00);
         repeat (200 + $urandom_range(1800)) @(posedge mclk);
         bus(1'b1, ISLC_CTRL_OFS, {29'h0, i == 3, i != 3, 1'b0});
         wait_bit(ISLC_S_LOOP);
         chk({30'h0, rdat[1:0]}, 32'h3);
         chk({30'h0, scl_oe, sda_oe}, 32'h0);
      end
      go(8'h01, 8'h01, 8'h00);
      wait_bit(ISLC_S_DONE);
      chk(32'(starts - s0), 32'd2);
      for (int p = 0; p < 2; p++) begin
         trig <= p[0];
         go({3'h0, p[0], 4'h9}, 8'h02, 8'h01);
         repeat (300) @(posedge mclk);
         chk(32'(starts - s0), 32'd0);
         pulse(p[0]);
         wait_bit(ISLC_S_DONE);
         chk({31'h0, rdat[ISLC_S_OVR]}, 32'h0);
         chk(32'(starts - s0), 32'd2);
         pulse(p[0]);
         repeat (300) @(posedge mclk);
         pulse(p[0]);
         wait_bit(ISLC_S_LOOP);
         chk({31'h0, rdat[ISLC_S_OVR]}, 32'h1);
      end
      stuck <= 1'b1;
      for (int h = 0; h < 2; h++) begin
         go({2'h0, h[0], 5'h01}, 8'h01, 8'h00);
         wait_bit(ISLC_S_STUCK);
         repeat (50) @(posedge mclk);
         chk({30'h0, scl_oe, sda_oe}, 32'h0);
      end
      stuck <= 1'b0;
      bus(1'b1, ISLC_CTRL_OFS, 32'h0000_0040);
      repeat (1000) @(posedge mclk);
      go(8'h01, 8'h01, 8'h00);
      wait_bit(ISLC_S_DONE);
      chk(32'(starts - s0), 32'd2);
      stuck <= 1'b1;
      go(8'h21, 8'h01, 8'h00);
      repeat (200) @(posedge mclk);
      stuck <= 1'b0;
      wait_bit(ISLC_S_DONE);
      chk({31'h0, rdat[ISLC_S_STUCK]}, 32'h0);
      chk(32'(starts - s0), 32'd2);
      end_of_test();
   end
   // cuts a hang short well past the expected run length
   initial begin
      #1_900_000;
      bad_count++;
      end_of_test();
   end
endmodule
bind islc_core islc_chk i_chk (.mclk(mclk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_i(scl_i), .scl_o(scl_o),
   .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .trig_i(trig_i), .irq(irq));
